// ### common/tmrps_pkg.sv
/*
 * Shared constants of the timer/counter with prescaler: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a single core clock; four core clocks make one instruction cycle.
 */
package tmrps_pkg;

   // ******************************************************************
   // Register map (byte addresses on the register bus)
   // ******************************************************************
   localparam logic [7:0] ADDR_COUNT   = 8'h00;
   localparam logic [7:0] ADDR_OPTION  = 8'h04;
   localparam logic [7:0] ADDR_INTCTRL = 8'h08;
   localparam logic [7:0] ADDR_STATUS  = 8'h0c;

   // ******************************************************************
   // Field positions
   // ******************************************************************
   localparam int OPT_PS_LSB   = 0;
   localparam int OPT_PS_W     = 3;
   localparam int OPT_ASSIGN   = 3;
   localparam int OPT_EDGE     = 4;
   localparam int OPT_SOURCE   = 5;
   localparam int INT_FLAG     = 2;
   localparam int INT_ENABLE   = 5;
   localparam int STS_SLEEP    = 0;
   localparam int STS_INHIBIT  = 1;
   localparam int STS_PRESC    = 2;

   // ******************************************************************
   // Reset values
   // ******************************************************************
   localparam logic [7:0] OPTION_RESET  = 8'h3f;
   localparam logic [7:0] INTCTRL_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET   = 8'h00;
   localparam logic [7:0] COUNT_MAX     = 8'hff;

   // ******************************************************************
   // Timing
   // ******************************************************************
   localparam int         CORE_PERIOD_NS   = 4;
   localparam int         PHASES_PER_CYCLE = 4;
   localparam logic [1:0] WRITE_INHIBIT    = 2'h2;
   localparam logic [1:0] PHASE_SECOND     = 2'h1;
   localparam logic [1:0] PHASE_FOURTH     = 2'h3;

endpackage

// ### logic/tmrps_phase_gen.sv
/*
 * Phase generator: splits the core clock into four internal phases and
 * gives a one-cycle enable on the second and the fourth phase.
 * Assumes the synchronous active-high reset starts the cycle at phase one.
 */
`timescale 1ns/1ps
`default_nettype none

module tmrps_phase_gen (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // Phase enables
   output var  logic secondPhaseClock,
   output var  logic fourthPhaseClock
);

   logic [1:0] phase_reg;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         phase_reg <= 2'h0;
      end else begin
         phase_reg <= phase_reg + 2'h1;
      end
   end

   always_comb begin
      secondPhaseClock = (phase_reg == tmrps_pkg::PHASE_SECOND);
      fourthPhaseClock = (phase_reg == tmrps_pkg::PHASE_FOURTH);
   end

endmodule // tmrps_phase_gen

`default_nettype wire

// ### logic/tmrps_prescaler.sv
/*
 * Shared 8-bit prescaler. Counts enable pulses, offers a symmetrical
 * divided level and a carry pulse at the end of each divided period.
 * Assumes the caller selects which source feeds countEn.
 */
`timescale 1ns/1ps
`default_nettype none

module tmrps_prescaler #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   // Control
   input  wire logic                 clearCount,
   input  wire logic                 countEn,
   input  wire logic [2:0]           ratioSel,
   // Divided outputs
   output var  logic                 dividedLevel,
   output var  logic                 carryPulse
);

   logic [WIDTH-1:0] count_reg;

   // Ones in every bit up to and including the selected stage.
   function automatic logic [WIDTH-1:0] stageMask(input logic [2:0] sel);
      logic [WIDTH-1:0] m;
      m = '0;
      for (int i = 0; i < WIDTH; i++) begin
         m[i] = (i <= int'(sel));
      end
      return m;
   endfunction

   always_ff @(posedge core_clk) begin
      if (reset || clearCount) begin
         count_reg <= '0;
      end else if (countEn) begin
         count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always_comb begin
      dividedLevel = count_reg[ratioSel];
      carryPulse   = countEn && ((count_reg & stageMask(ratioSel)) == stageMask(ratioSel));
   end

endmodule // tmrps_prescaler

`default_nettype wire

// ### logic/tmrps_top.sv
/*
 * Timer/counter with shared prescaler, reached over a classic Wishbone
 * slave. Counts instruction cycles or edges of the external count pin.
 * Assumes all inputs are synchronous to core_clk and that the watchdog
 * and sleep controller sit outside and drive their pins directly.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Wrap from maximum to zero sets overflow flag.
// - Source clear counts every instruction cycle without prescaler.
// - Count write blocks incrementing two cycles.
// - Source set counts external pin edges.
// - Edge select: clear rising, set falling.
// - Assignment bit shares prescaler with watchdog.
// - Prescaler count has no software access.
// - Ratios one in two up to 256.
// - Enable bit clear masks overflow interrupt.
// - Timer halts during sleep, no wake-up.
// - No prescaler: pin passes straight through.
// - Prescaler output sampled on phases two, four.
// - Prescaler divides pin to symmetrical output.
// - External-source increment only after synchronising stage.
module tmrps_top (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Wishbone slave
   input  wire logic        wbCycI,
   input  wire logic        wbStbI,
   input  wire logic        wbWeI,
   input  wire logic [7:0]  wbAdrI,
   input  wire logic [3:0]  wbSelI,
   input  wire logic [31:0] wbDatI,
   output var  logic [31:0] wbDatO,
   output var  logic        wbAckO,
   // External count pin
   input  wire logic        externalCountInput,
   // Power and watchdog
   input  wire logic        sleepMode,
   input  wire logic        watchdogTick,
   output var  logic        watchdogPrescaledTick,
   // Interrupt request
   output var  logic        overflowIrq
);

   // ******************************************************************
   // Declarations
   // ******************************************************************
   logic [7:0]  count_reg;
   logic [7:0]  count_next;
   logic [7:0]  option_reg;
   logic        flag_reg;
   logic        enable_reg;
   logic [1:0]  inhibit_reg;
   logic        pinPrev_reg;
   logic        sample_reg;
   logic        extEvent_reg;
   logic        wbAck_reg;
   logic [31:0] wbDat_reg;
   logic        irq_reg;
   logic        wdtTick_reg;

   logic        secondPhaseClock;
   logic        fourthPhaseClock;
   logic        instrTick;
   logic        busAccess;
   logic        busWrite;
   logic        writeCount;
   logic        writeOption;
   logic        writeIntctrl;
   logic        sourceSel;
   logic        edgeSel;
   logic        prescToWdt;
   logic [2:0]  ratioSel;
   logic        polarPin;
   logic        pinEdge;
   logic        prescEn;
   logic        prescLevel;
   logic        prescCarry;
   logic        prescOut;
   logic        phaseSample;
   logic        timerEvent;
   logic        incrementNow;
   logic        wrapNow;

   // Decodes one register word; writes also need the low byte lane.
   function automatic logic regHit(input logic [7:0] adr, input logic [7:0] off);
      return (adr[7:2] == off[7:2]);
   endfunction

   // ******************************************************************
   // Option fields
   // ******************************************************************
   always_comb begin
      sourceSel  = option_reg[tmrps_pkg::OPT_SOURCE];
      edgeSel    = option_reg[tmrps_pkg::OPT_EDGE];
      prescToWdt = option_reg[tmrps_pkg::OPT_ASSIGN];
      ratioSel   = option_reg[tmrps_pkg::OPT_PS_LSB +: tmrps_pkg::OPT_PS_W];
   end

   // ******************************************************************
   // Phase clocks
   // ******************************************************************
   tmrps_phase_gen u_phase (
      .core_clk         (core_clk),
      .reset            (reset),
      .secondPhaseClock (secondPhaseClock),
      .fourthPhaseClock (fourthPhaseClock)
   );

   // One instruction cycle ends at each fourth phase.
   assign instrTick = fourthPhaseClock;

   // ******************************************************************
   // Bus decode
   // ******************************************************************
   always_comb begin
      busAccess    = wbCycI && wbStbI && !wbAck_reg;
      busWrite     = busAccess && wbWeI && wbSelI[0];
      writeCount   = busWrite && regHit(wbAdrI, tmrps_pkg::ADDR_COUNT);
      writeOption  = busWrite && regHit(wbAdrI, tmrps_pkg::ADDR_OPTION);
      writeIntctrl = busWrite && regHit(wbAdrI, tmrps_pkg::ADDR_INTCTRL);
   end

   // ******************************************************************
   // External pin edge and prescaler source
   // ******************************************************************
   // Inverting the pin for falling-edge mode lets the rest of the path
   // always look for a rising edge.
   assign polarPin = edgeSel ? !externalCountInput : externalCountInput;

   // The pin idles low, so after reset the polarised level equals the
   // reset edge select; starting from it avoids a false edge.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pinPrev_reg <= tmrps_pkg::OPTION_RESET[tmrps_pkg::OPT_EDGE];
      end else begin
         pinPrev_reg <= polarPin;
      end
   end

   assign pinEdge = polarPin && !pinPrev_reg;

   always_comb begin
      if (prescToWdt) begin
         prescEn = watchdogTick;
      end else if (sleepMode) begin
         prescEn = 1'b0;
      end else if (sourceSel) begin
         prescEn = pinEdge;
      end else begin
         prescEn = instrTick;
      end
   end

   // The count itself has no bus path; a count write clears it unless the prescaler is assigned to the watchdog.
   tmrps_prescaler #(
      .WIDTH (8)
   ) u_presc (
      .core_clk     (core_clk),
      .reset        (reset),
      .clearCount   (writeCount && !prescToWdt),
      .countEn      (prescEn),
      .ratioSel     (ratioSel),
      .dividedLevel (prescLevel),
      .carryPulse   (prescCarry)
   );

   // Without the prescaler the pin itself is the prescaler output.
   assign prescOut = prescToWdt ? polarPin : prescLevel;

   // ******************************************************************
   // Synchronisation on the second and fourth phases
   // ******************************************************************
   // A pin level shorter than two core clocks can fall between two
   // samples and be lost; the source must respect the pulse widths.
   assign phaseSample = secondPhaseClock || fourthPhaseClock;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sample_reg <= tmrps_pkg::OPTION_RESET[tmrps_pkg::OPT_EDGE];
      end else if (phaseSample) begin
         sample_reg <= prescOut;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         extEvent_reg <= 1'b0;
      end else begin
         extEvent_reg <= phaseSample && prescOut && !sample_reg;
      end
   end

   // ******************************************************************
   // Increment decision
   // ******************************************************************
   always_comb begin
      if (sourceSel) begin
         timerEvent = extEvent_reg;
      end else if (prescToWdt) begin
         timerEvent = instrTick;
      end else begin
         timerEvent = prescCarry;
      end
      incrementNow = timerEvent && !sleepMode && (inhibit_reg == 2'h0);
      wrapNow      = incrementNow && (count_reg == tmrps_pkg::COUNT_MAX);
   end

   // ******************************************************************
   // Count register
   // ******************************************************************
   always_comb begin
      if (writeCount) begin
         count_next = wbDatI[7:0];
      end else if (incrementNow) begin
         count_next = count_reg + 8'h01;
      end else begin
         count_next = count_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         count_reg <= tmrps_pkg::COUNT_RESET;
      end else begin
         count_reg <= count_next;
      end
   end

   // Two instruction cycles of hold-off after a count write; software
   // compensates by writing an adjusted value.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         inhibit_reg <= 2'h0;
      end else if (writeCount) begin
         inhibit_reg <= tmrps_pkg::WRITE_INHIBIT;
      end else if (instrTick && inhibit_reg != 2'h0) begin
         inhibit_reg <= inhibit_reg - 2'h1;
      end
   end

   // ******************************************************************
   // Option register
   // ******************************************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         option_reg <= tmrps_pkg::OPTION_RESET;
      end else if (writeOption) begin
         option_reg <= {2'h0, wbDatI[5:0]};
      end
   end

   // ******************************************************************
   // Interrupt control: flag and enable
   // ******************************************************************
   // A wrap in the same cycle as a software clear keeps the flag set.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         flag_reg <= 1'b0;
      end else if (wrapNow) begin
         flag_reg <= 1'b1;
      end else if (writeIntctrl) begin
         flag_reg <= wbDatI[tmrps_pkg::INT_FLAG];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         enable_reg <= tmrps_pkg::INTCTRL_RESET[tmrps_pkg::INT_ENABLE];
      end else if (writeIntctrl) begin
         enable_reg <= wbDatI[tmrps_pkg::INT_ENABLE];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= flag_reg && enable_reg;
      end
   end

   assign overflowIrq = irq_reg;

   // ******************************************************************
   // Watchdog side of the prescaler
   // ******************************************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wdtTick_reg <= 1'b0;
      end else if (prescToWdt) begin
         wdtTick_reg <= prescCarry;
      end else begin
         wdtTick_reg <= watchdogTick;
      end
   end

   assign watchdogPrescaledTick = wdtTick_reg;

   // ******************************************************************
   // Wishbone answer
   // ******************************************************************
   // Every access, mapped or not, is answered one cycle after it is
   // seen; unmapped reads return zero and unmapped writes are dropped.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wbAck_reg <= 1'b0;
      end else begin
         wbAck_reg <= busAccess;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wbDat_reg <= 32'h0000_0000;
      end else if (busAccess) begin
         if (regHit(wbAdrI, tmrps_pkg::ADDR_COUNT)) begin
            wbDat_reg <= {24'h00_0000, count_reg};
         end else if (regHit(wbAdrI, tmrps_pkg::ADDR_OPTION)) begin
            wbDat_reg <= {24'h00_0000, option_reg};
         end else if (regHit(wbAdrI, tmrps_pkg::ADDR_INTCTRL)) begin
            wbDat_reg <= {26'h000_0000, enable_reg, 2'h0, flag_reg, 2'h0};
         end else if (regHit(wbAdrI, tmrps_pkg::ADDR_STATUS)) begin
            wbDat_reg <= {29'h0000_0000, !prescToWdt, (inhibit_reg != 2'h0), sleepMode};
         end else begin
            wbDat_reg <= 32'h0000_0000;
         end
      end
   end

   assign wbAckO = wbAck_reg;
   assign wbDatO = wbDat_reg;

endmodule // tmrps_top

`default_nettype wire

// ### sim/tmrps_properties.sv
/* Concurrent checks on the timer top: bus handshake, read data, interrupt
   and watchdog pass-through. Sees only the top ports; bound below. */
`timescale 1ns/1ps
`default_nettype none
module tmrps_properties (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        reset,
   // Bus
   input wire logic        wbCycI,
   input wire logic        wbStbI,
   input wire logic        wbWeI,
   input wire logic [7:0]  wbAdrI,
   input wire logic [3:0]  wbSelI,
   input wire logic [31:0] wbDatI,
   input wire logic [31:0] wbDatO,
   input wire logic        wbAckO,
   // Pins
   input wire logic        externalCountInput,
   input wire logic        sleepMode,
   input wire logic        watchdogTick,
   input wire logic        watchdogPrescaledTick,
   input wire logic        overflowIrq
);
   logic       wrTaken;
   logic [7:0] optShadow;
   logic [7:0] lastCnt;
   logic [3:0] sinceWr;
   assign wrTaken = wbCycI && wbStbI && wbWeI && wbSelI[0] && !wbAckO;
   // ****************************************************
   // Shadow state
   // ****************************************************
   // The design keeps option and hold-off private, so they are mirrored here.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         optShadow <= tmrps_pkg::OPTION_RESET;
         lastCnt   <= 8'h00;
         sinceWr   <= 4'hf;
      end else begin
         if (wrTaken && wbAdrI == tmrps_pkg::ADDR_OPTION) begin
            optShadow <= wbDatI[7:0];
         end
         if (wrTaken && wbAdrI == tmrps_pkg::ADDR_COUNT) begin
            lastCnt <= wbDatI[7:0];
            sinceWr <= 4'h0;
         end else if (sinceWr != 4'hf) begin
            sinceWr <= sinceWr + 4'h1;
         end
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence busReq;
      wbCycI && wbStbI && !wbAckO;
   endsequence
   sequence ictlWr;
      wrTaken && wbAdrI == tmrps_pkg::ADDR_INTCTRL;
   endsequence
   ack_latency_a: assert property (busReq |=> wbAckO)
      else $error("request not acknowledged next cycle");
   ack_pulse_a: assert property (wbAckO |=> !wbAckO)
      else $error("acknowledge longer than one cycle");
   ack_cause_a: assert property (wbAckO |-> $past(wbCycI && wbStbI))
      else $error("acknowledge without request");
   high_bits_zero_a: assert property (wbAckO |-> wbDatO[31:8] == 24'h0)
      else $error("read data above the low byte not zero");
   unmapped_zero_a: assert property (
      wbAckO && !wbWeI && wbAdrI[7:4] != 4'h0 |-> wbDatO == 32'h0)
      else $error("unmapped read not zero");
   option_read_a: assert property (
      wbAckO && !wbWeI && wbAdrI == tmrps_pkg::ADDR_OPTION |-> wbDatO[7:0] == (optShadow & 8'h3f))
      else $error("option read differs from last write");
   count_hold_a: assert property (
      wbAckO && !wbWeI && wbAdrI == tmrps_pkg::ADDR_COUNT && sinceWr <= 4'h8 |-> wbDatO[7:0] == lastCnt)
      else $error("count moved during write hold-off");
   irq_mask_a: assert property (ictlWr ##0 !wbDatI[5] |-> ##2 !overflowIrq)
      else $error("interrupt not masked by enable clear");
   irq_set_a: assert property (ictlWr ##0 (wbDatI[5] && wbDatI[2]) |-> ##2 overflowIrq)
      else $error("interrupt missing with flag and enable set");
   status_sleep_a: assert property (
      wbAckO && !wbWeI && wbAdrI == tmrps_pkg::ADDR_STATUS |-> wbDatO[tmrps_pkg::STS_SLEEP] == $past(sleepMode))
      else $error("status sleep bit differs from sleep pin");
   wdog_pass_a: assert property (
      !optShadow[tmrps_pkg::OPT_ASSIGN] |=> watchdogPrescaledTick == $past(watchdogTick))
      else $error("watchdog tick not passed through");
endmodule // tmrps_properties
bind tmrps_top tmrps_properties u_props (
   .core_clk(core_clk), .reset(reset), .wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI),
   .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAckO(wbAckO),
   .externalCountInput(externalCountInput), .sleepMode(sleepMode), .watchdogTick(watchdogTick),
   .watchdogPrescaledTick(watchdogPrescaledTick), .overflowIrq(overflowIrq));
`default_nettype wire

// ### sim/tmrps_pulse_src.sv
/* External pulse source on the count pin: toggles the pin a requested
   number of times. Assumes the bench raises startReq for one cycle. */
`timescale 1ns/1ps
`default_nettype none
module tmrps_pulse_src #(
   parameter int HOLD = 2
) (
   // Clock
   input  wire logic       core_clk,
   // Burst request
   input  wire logic       startReq,
   input  wire logic [3:0] toggleCount,
   // Pin and status
   output var  logic       pinOut,
   output var  logic       busy
);
   logic [3:0] togglesLeft;
   int         waitLeft;
   initial begin
      pinOut = 1'b0;
      busy   = 1'b0;
   end
   // Each level is held HOLD core clocks, the shortest width the pin allows.
   always @(posedge core_clk) begin
      if (startReq && !busy) begin
         togglesLeft <= toggleCount;
         waitLeft    <= HOLD;
         busy        <= 1'b1;
      end else if (busy) begin
         if (waitLeft > 1) begin
            waitLeft <= waitLeft - 1;
         end else if (togglesLeft != 4'h0) begin
            pinOut      <= !pinOut;
            togglesLeft <= togglesLeft - 4'h1;
            waitLeft    <= HOLD;
         end else begin
            busy <= 1'b0;
         end
      end
   end
endmodule // tmrps_pulse_src
`default_nettype wire

// ### sim/tmrps_tb_top.sv
/* Self-checking bench for the timer top, driving registers over classic
   Wishbone and the count pin through the pulse source model. */
`timescale 1ns/1ps
`default_nettype none
module tmrps_tb_top;
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic        wbCycI = 1'b0;
   logic        wbStbI = 1'b0;
   logic        wbWeI = 1'b0;
   logic [7:0]  wbAdrI = 8'h00;
   logic [3:0]  wbSelI = 4'h0;
   logic [31:0] wbDatI = 32'h0;
   logic [31:0] wbDatO;
   logic        wbAckO;
   logic        pin;
   logic        busy;
   logic        startReq = 1'b0;
   logic [3:0]  toggleCount = 4'h0;
   logic        sleepMode = 1'b0;
   logic        wdTick = 1'b0;
   logic        wdOut;
   logic        irq;
   logic [31:0] q1;
   logic [31:0] q2;
   int          badCount = 0;
   int          nCompared = 0;
   int          wdSeen = 0;
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) if (wdOut === 1'b1) wdSeen <= wdSeen + 1;
   tmrps_top u_dut (
      .core_clk(core_clk), .reset(reset), .wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI),
      .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAckO(wbAckO),
      .externalCountInput(pin), .sleepMode(sleepMode), .watchdogTick(wdTick),
      .watchdogPrescaledTick(wdOut), .overflowIrq(irq));
   tmrps_pulse_src u_src (
      .core_clk(core_clk), .startReq(startReq), .toggleCount(toggleCount),
      .pinOut(pin), .busy(busy));
   // ****************************************************
   // Tasks
   // ****************************************************
   task final_report;
      if (badCount == 0 && nCompared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      nCompared++;
      if (got !== exp) begin
         badCount++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task xfer(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
      @(posedge core_clk);
      wbCycI <= 1'b1;
      wbStbI <= 1'b1;
      wbWeI  <= w;
      wbAdrI <= a;
      wbSelI <= 4'h1;
      wbDatI <= {24'h0, d};
      do @(posedge core_clk); while (wbAckO !== 1'b1);
      q = wbDatO;
      wbCycI <= 1'b0;
      wbStbI <= 1'b0;
      wbWeI  <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      xfer(a, 1'b1, d, q1);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      xfer(a, 1'b0, 8'h00, q1);
      chk(q1, {24'h0, e});
   endtask
   // Counts increments over a gap whose taken-edge span is gap + 3 cycles.
   task rate(input logic [7:0] opt, input int gap, input logic [7:0] e);
      wr(tmrps_pkg::ADDR_OPTION, opt);
      xfer(tmrps_pkg::ADDR_COUNT, 1'b0, 8'h00, q1);
      repeat (gap) @(posedge core_clk);
      xfer(tmrps_pkg::ADDR_COUNT, 1'b0, 8'h00, q2);
      chk((q2 - q1) & 32'hff, {24'h0, e});
   endtask
   task toggle(input logic [7:0] opt, input logic [3:0] n, input logic [7:0] e);
      wr(tmrps_pkg::ADDR_OPTION, opt);
      wr(tmrps_pkg::ADDR_COUNT, 8'h00);
      repeat (12) @(posedge core_clk);
      startReq    <= 1'b1;
      toggleCount <= n;
      @(posedge core_clk);
      startReq <= 1'b0;
      @(posedge core_clk);
      while (busy) @(posedge core_clk);
      repeat (8) @(posedge core_clk);
      rd(tmrps_pkg::ADDR_COUNT, e);
   endtask
   task wdPulses(input int n, input int e);
      int base;
      base = wdSeen;
      repeat (n) begin
         @(posedge core_clk);
         wdTick <= 1'b1;
         @(posedge core_clk);
         wdTick <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
      repeat (4) @(posedge core_clk);
      chk(wdSeen - base, e);
   endtask
   // ****************************************************
   // Tests
   // ****************************************************
   initial begin
      repeat (30000) @(posedge core_clk);
      badCount++;
      final_report;
   end
   initial begin
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      rd(tmrps_pkg::ADDR_OPTION, 8'h3f);
      rd(tmrps_pkg::ADDR_INTCTRL, 8'h00);
      rd(tmrps_pkg::ADDR_COUNT, 8'h00);
      wr(8'h10, 8'hff);
      rd(8'h10, 8'h00);
      rate(8'h08, 37, 8'h0a);
      wr(tmrps_pkg::ADDR_COUNT, 8'h40);
      rd(tmrps_pkg::ADDR_STATUS, 8'h02);
      rd(tmrps_pkg::ADDR_COUNT, 8'h40);
      for (int n = 0; n < 8; n++) rate({5'h0, n[2:0]}, (16 << n) - 3, 8'h02);
      wr(tmrps_pkg::ADDR_OPTION, 8'h08);
      wr(tmrps_pkg::ADDR_INTCTRL, 8'h00);
      wr(tmrps_pkg::ADDR_COUNT, 8'hfe);
      repeat (60) @(posedge core_clk);
      rd(tmrps_pkg::ADDR_INTCTRL, 8'h04);
      chk({31'h0, irq}, 32'h0);
      wr(tmrps_pkg::ADDR_INTCTRL, 8'h24);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h1);
      wr(tmrps_pkg::ADDR_INTCTRL, 8'h00);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      sleepMode <= 1'b1;
      rd(tmrps_pkg::ADDR_STATUS, 8'h01);
      rate(8'h08, 40, 8'h00);
      sleepMode <= 1'b0;
      toggle(8'h28, 4'h3, 8'h02);
      toggle(8'h38, 4'h3, 8'h02);
      toggle(8'h20, 4'h8, 8'h02);
      wr(tmrps_pkg::ADDR_OPTION, 8'h08);
      wdPulses(4, 2);
      wr(tmrps_pkg::ADDR_OPTION, 8'h00);
      wdPulses(3, 3);
      final_report;
   end
endmodule // tmrps_tb_top
`default_nettype wire
